// ==== bench/sdrs_mem_model.sv ====
/* sdram model: keeps the open rows and returns a word cas cycles after a read.
 * assumes commands from the scheduler on the shared clock, burst length one. */
`timescale 1ns/1ns
`default_nettype none
module sdrs_mem_model
    import sdrs_pkg::*;
(
    input wire logic clock,
    input wire logic cas3,
    input wire sdrs_cmd_e cmd,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ROW_W-1:0] addr,
    output logic [DATA_W-1:0] dq,
    output int viol
);
    logic [ROW_W-1:0] row_q [NBANK];
    logic [NBANK-1:0] open_q = '0;
    logic [2:0] vld_q = '0;
    logic [DATA_W-1:0] pipe_q [3];
    logic [DATA_W-1:0] last_q = '0;
    int viol_q = 0;
    logic sel;
    // word stands only in the cycle cas cycles after the read
    assign sel = cas3 ? vld_q[2] : vld_q[1];
    // a released bus shows the inverse of the last word
    assign dq = sel ? pipe_q[cas3 ? 2 : 1] : ~last_q;
    assign viol = viol_q;
    // open row book and read data pipe
    always @(posedge clock)
    begin
        vld_q <= {vld_q[1:0], cmd == CMD_RD};
        pipe_q[0] <= {bank, row_q[bank][4:0], addr[COL_W-1:0]};
        pipe_q[1] <= pipe_q[0];
        pipe_q[2] <= pipe_q[1];
        if (sel)
            last_q <= dq;
        if (cmd == CMD_PRE)
            open_q[bank] <= 1'b0;
        if (cmd == CMD_ACT)
            row_q[bank] <= addr;
        if (cmd == CMD_ACT)
            open_q[bank] <= 1'b1;
        if ((cmd == CMD_ACT && open_q[bank]) || (cmd == CMD_RD && !open_q[bank]))
            viol_q <= viol_q + 1;
    end
endmodule : sdrs_mem_model
`default_nettype wire

// ==== bench/tb.sv ====
/* self-checking testbench of the read path scheduler.
 * assumes sdrs_pkg, sdrs_read_sched and the model sdrs_mem_model. */
`timescale 1ns/1ns
`default_nettype none
module tb import sdrs_pkg::*;;
    logic clock = 0, nrst = 0, cas3 = 0, rv = 0, cont = 0, brk = 0;
    logic [TIM_W-1:0] trp = 4'h2, trcd = 4'h3;
    logic [BANK_W-1:0] bk = '0, mbank;
    logic [ROW_W-1:0] row = '0, maddr;
    logic [COL_W-1:0] col = '0;
    sdrs_burst_e kind = BST_SINGLE;
    logic ready, vld, last;
    logic [DATA_W-1:0] data, dq;
    sdrs_cmd_e cmd;
    int viol, cyc = 0, t0 = 0, fail_count = 0, samples_checked = 0;
    logic [31:0] ct[$], cq[$], aq[$], wt[$], wd[$], wl[$];
    // -----------------------------------------------------------
    // design and sdram model
    // -----------------------------------------------------------
    sdrs_read_sched DUT (.clock(clock), .nrst(nrst), .cfg_trp(trp), .cfg_trcd(trcd),
        .cfg_cas_lat3(cas3), .req_valid(rv), .req_bank(bk), .req_row(row), .req_col(col),
        .req_kind(kind), .burst_cont(cont), .burst_break(brk), .req_ready_q(ready),
        .rd_valid_q(vld), .rd_data_q(data), .rd_last_q(last), .mem_cmd_q(cmd),
        .mem_bank_q(mbank), .mem_addr_q(maddr), .mem_dq(dq));
    sdrs_mem_model mem (.clock(clock), .cas3(cas3), .cmd(cmd), .bank(mbank),
        .addr(maddr), .dq(dq), .viol(viol));
    // 10 mhz clock
    always #50 clock = ~clock;
    // -----------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // log commands and returned words with the cycle they stand in
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cmd != CMD_NOP)
        begin
            ct.push_back(cyc);
            cq.push_back(32'(cmd));
            aq.push_back(32'(maddr));
        end
        if (vld === 1'b1)
        begin
            wt.push_back(cyc);
            wd.push_back(32'(data));
            wl.push_back(32'(last));
        end
        if (cyc == 6000)
        begin
            fail_count++;
            results();
        end
    end
    // one request, then wait until every read has drained
    task automatic go(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
        input logic [COL_W-1:0] c, input sdrs_burst_e k);
        @(negedge clock);
        while (ready !== 1'b1)
            @(negedge clock);
        ct.delete();
        cq.delete();
        aq.delete();
        wt.delete();
        wd.delete();
        wl.delete();
        bk = b;
        row = r;
        col = c;
        kind = k;
        rv = 1'b1;
        t0 = cyc;
        @(negedge clock);
        rv = 1'b0;
        repeat (2) @(negedge clock);
        while (ready !== 1'b1)
            @(negedge clock);
        repeat (3) @(negedge clock);
    endtask : go
    task automatic words(input int n, input logic [BANK_W-1:0] b,
        input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
        chk(wd.size(), n);
        for (int i = 0; i < n; i++)
            chk(wd[i], 32'({b, r[4:0], c + 9'(i)}));
    endtask : words
    function automatic int nrd();
        nrd = 0;
        foreach (cq[i])
            nrd += int'(cq[i] == 32'(CMD_RD));
    endfunction : nrd
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_first();
        go(2'h0, 13'h0005, 9'h00a, BST_SINGLE);
        chk(cq[0], 32'(CMD_ACT));
        chk(ct[0], t0 + 2);
        chk(ct[1] - ct[0], 3);
        chk(aq[2], 32'h00b);
        chk(wt[0] - ct[1], 3);
        chk(wl[0], 1);
        words(1, 2'h0, 13'h0005, 9'h00a);
        $display("test first_access done");
    endtask : t_first
    task automatic t_hit();
        go(2'h0, 13'h0005, 9'h00b, BST_SINGLE);
        chk(wt[0], t0 + 1);
        chk(cq[0], 32'(CMD_RD));
        chk(aq[0], 32'h00c);
        words(1, 2'h0, 13'h0005, 9'h00b);
        $display("test prefetch_hit done");
    endtask : t_hit
    task automatic t_miss();
        {trp, cas3} = {4'h3, 1'b1};
        go(2'h0, 13'h0009, 9'h000, BST_SINGLE);
        chk(cq[0], 32'(CMD_PRE));
        chk(cq[1], 32'(CMD_ACT));
        chk(ct[1] - ct[0], 3);
        chk(ct[2] - ct[1], 3);
        chk(wt[0] - ct[2], 4);
        words(1, 2'h0, 13'h0009, 9'h000);
        // zero precharge field counts as one cycle, shortest row-to-column delay
        cas3 = 1'b0;
        trp = 4'h0;
        trcd = 4'h1;
        go(2'h0, 13'h000a, 9'h000, BST_SINGLE);
        chk(cq[0], 32'(CMD_PRE));
        chk(ct[1] - ct[0], 1);
        chk(ct[2] - ct[1], 1);
        chk(wt[0] - ct[2], 3);
        words(1, 2'h0, 13'h000a, 9'h000);
        trcd = 4'h3;
        $display("test row_miss done");
    endtask : t_miss
    task automatic t_fixed();
        sdrs_burst_e ks[3];
        ks = '{BST_FIX4, BST_FIX8, BST_FIX16};
        for (int i = 0; i < 3; i++)
        begin
            go(2'h1, 13'h0002, 9'h020, ks[i]);
            chk(nrd(), 4 << i);
            chk(wl[(4 << i) - 1], 1);
            words(4 << i, 2'h1, 13'h0002, 9'h020);
        end
        $display("test fixed_bursts done");
    endtask : t_fixed
    task automatic t_incr();
        go(2'h1, 13'h0002, 9'h040, BST_INCR);
        chk(nrd(), 2);
        chk(wl[0], 0);
        cont = 1'b1;
        go(2'h1, 13'h0002, 9'h1fc, BST_INCR);
        chk(nrd(), 4);
        words(4, 2'h1, 13'h0002, 9'h1fc);
        cont = 1'b0;
        $display("test incr_bursts done");
    endtask : t_incr
    task automatic t_break();
        brk = 1'b1;
        go(2'h1, 13'h0002, 9'h080, BST_FIX16);
        chk(nrd(), wd.size() + 1);
        chk(wd.size() < 16, 1);
        words(wd.size(), 2'h1, 13'h0002, 9'h080);
        brk = 1'b0;
        $display("test broken_burst done");
    endtask : t_break
    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
        t_first();
        t_hit();
        t_miss();
        t_fixed();
        t_incr();
        t_break();
        chk(viol, 0);
        results();
    end
endmodule : tb
`default_nettype wire

// ==== core/sdrs_read_sched.sv ====
/*
 * read path scheduler of the dynamic_memory_controller: takes reads from an
 * internal master and drives sdram precharge, activate and read commands.
 * assumes the sdram runs on clock, returns a word cas cycles after each read,
 * the memory_timing_config fields stay stable while a request is in flight,
 * and the master takes every returned word (no back-pressure).
 */
// Notes on behaviour
// - single reads, open-ended incrementing bursts and fixed bursts are all served.
// - the open row of every bank is recorded and an open-row hit skips activation.
// - on a row miss in an open bank a precharge, an activate and then the read go out.
// - precharge to activate spacing is the row-precharge field in clock cycles.
// - activate to read spacing is the row-to-column field in clock cycles.
// - read data is taken two or three cycles after the read, as cas latency selects.
// - single and incrementing reads that stop short of the last column end with an anticipated read of the next column.
// - fixed bursts of four, eight or sixteen words never read beyond their length.
// - a broken fixed burst carries on as an incrementing burst of open length.
`timescale 1ns/1ns
`default_nettype none
module sdrs_read_sched
    import sdrs_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [TIM_W-1:0] cfg_trp,
    input wire logic [TIM_W-1:0] cfg_trcd,
    input wire logic cfg_cas_lat3,
    input wire logic req_valid,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic [ROW_W-1:0] req_row,
    input wire logic [COL_W-1:0] req_col,
    input wire sdrs_burst_e req_kind,
    input wire logic burst_cont,
    input wire logic burst_break,
    output logic req_ready_q,
    output logic rd_valid_q,
    output logic [DATA_W-1:0] rd_data_q,
    output logic rd_last_q,
    output var sdrs_cmd_e mem_cmd_q,
    output logic [BANK_W-1:0] mem_bank_q,
    output logic [ROW_W-1:0] mem_addr_q,
    input wire logic [DATA_W-1:0] mem_dq
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    // two flops release the reset cleanly on clock
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sdrs_state_e state_q, state_d;
    sdrs_burst_e kind_q, kind_d, ekind;
    sdrs_cmd_e mem_cmd_d;
    logic [BANK_W-1:0] bank_q, bank_d, mem_bank_d, pf_bank_q, pf_bank_d;
    logic [ROW_W-1:0] row_q, row_d, mem_addr_d, pf_row_q, pf_row_d;
    logic [COL_W-1:0] col_q, col_d, pf_col_q, pf_col_d;
    logic [4:0] rem_q, rem_d;
    logic first_q, first_d, req_ready_d, iss_pf_q, iss_pf_d, iss_last_q, iss_last_d;
    logic rd_valid_d, rd_last_d, pf_valid_q, pf_valid_d, more, pf_hit, tm_load, tm_done;
    logic [DATA_W-1:0] rd_data_d, pf_data_q, pf_data_d;
    logic [TIM_W-1:0] tm_val, rcd;
    logic [2:0] pipe_q [PIPE_N];
    logic [2:0] pipe_d [PIPE_N];
    logic [2:0] cap;
    logic [NBANK-1:0] open_q, open_d;
    logic [ROW_W-1:0] orow_q [NBANK];
    logic [ROW_W-1:0] orow_d [NBANK];

    sdrs_wait_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .load(tm_load),
        .load_val(tm_val),
        .expired(tm_done)
    );

    // ------------------------------------------------------------
    // open row table
    // ------------------------------------------------------------
    // follows the issued commands: precharge closes, activate opens
    always_comb
    begin
        open_d = open_q;
        orow_d = orow_q;
        if (mem_cmd_q == CMD_PRE)
            open_d[mem_bank_q] = 1'b0;
        if (mem_cmd_q == CMD_ACT)
        begin
            open_d[mem_bank_q] = 1'b1;
            orow_d[mem_bank_q] = mem_addr_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            open_q <= '0;
            for (int i = 0; i < NBANK; i++)
                orow_q[i] <= '0;
        end
        else
        begin
            open_q <= open_d;
            orow_q <= orow_d;
        end
    end

    // ------------------------------------------------------------
    // cas pipeline: tag is {valid, prefetch, last}
    // ------------------------------------------------------------
    always_comb
    begin
        pipe_d[0] = {mem_cmd_q == CMD_RD, iss_pf_q, iss_last_q};
        for (int i = 1; i < PIPE_N; i++)
            pipe_d[i] = pipe_q[i-1];
        cap = cfg_cas_lat3 ? pipe_q[2] : pipe_q[1];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            for (int i = 0; i < PIPE_N; i++)
                pipe_q[i] <= 3'h0;
        else
            pipe_q <= pipe_d;
    end

    // ------------------------------------------------------------
    // scheduler and data return
    // ------------------------------------------------------------
    assign rcd = eff_tim(cfg_trcd);
    assign pf_hit = pf_valid_q && !is_fixed(req_kind) && req_bank == pf_bank_q
                    && req_row == pf_row_q && req_col == pf_col_q;
    assign ekind = (is_fixed(kind_q) && burst_break) ? BST_INCR : kind_q;
    assign more = (ekind == BST_SINGLE) ? (rem_q != 5'h00) : (first_q || burst_cont);

    always_comb
    begin
        state_d = state_q;
        kind_d = kind_q;
        bank_d = bank_q;
        row_d = row_q;
        col_d = col_q;
        rem_d = rem_q;
        first_d = first_q;
        req_ready_d = req_ready_q;
        mem_cmd_d = CMD_NOP;
        mem_bank_d = mem_bank_q;
        mem_addr_d = mem_addr_q;
        iss_pf_d = 1'b0;
        iss_last_d = 1'b0;
        rd_valid_d = 1'b0;
        rd_last_d = 1'b0;
        rd_data_d = rd_data_q;
        pf_valid_d = pf_valid_q;
        pf_data_d = pf_data_q;
        pf_bank_d = pf_bank_q;
        pf_row_d = pf_row_q;
        pf_col_d = pf_col_q;
        tm_load = 1'b0;
        tm_val = eff_tim(cfg_trp);
        // word arriving from the sdram
        if (cap[2])
        begin
            if (cap[1])
            begin
                pf_valid_d = 1'b1;
                pf_data_d = mem_dq;
            end
            else
            begin
                rd_valid_d = 1'b1;
                rd_data_d = mem_dq;
                rd_last_d = cap[0];
            end
        end
        unique case (state_q)
            S_IDLE:
                if (req_valid && req_ready_q)
                begin
                    req_ready_d = 1'b0;
                    kind_d = req_kind;
                    bank_d = req_bank;
                    row_d = req_row;
                    col_d = req_col;
                    rem_d = burst_words(req_kind);
                    first_d = 1'b1;
                    pf_valid_d = 1'b0;
                    if (pf_hit)
                    begin
                        // anticipated word answers at once
                        rd_valid_d = 1'b1;
                        rd_data_d = pf_data_q;
                        rd_last_d = (req_kind == BST_SINGLE);
                        col_d = req_col + 9'h001;
                        rem_d = 5'h00;
                        first_d = 1'b0;
                        state_d = S_READ;
                    end
                    else if (open_q[req_bank] && orow_q[req_bank] == req_row)
                        state_d = S_READ;
                    else if (open_q[req_bank])
                        state_d = S_PRE;
                    else
                        state_d = S_ACT;
                end
            S_PRE:
            begin
                mem_cmd_d = CMD_PRE;
                mem_bank_d = bank_q;
                tm_load = 1'b1;
                state_d = S_WRP;
            end
            S_WRP, S_ACT:
                if (state_q == S_ACT || tm_done)
                begin
                    mem_cmd_d = CMD_ACT;
                    mem_bank_d = bank_q;
                    mem_addr_d = row_q;
                    tm_load = 1'b1;
                    tm_val = rcd - TIM_MIN;
                    state_d = (rcd == TIM_MIN) ? S_READ : S_WRCD;
                end
            S_WRCD:
                if (tm_done)
                    state_d = S_READ;
            S_READ:
            begin
                kind_d = ekind;
                first_d = 1'b0;
                mem_bank_d = bank_q;
                mem_addr_d = {{(ROW_W-COL_W){1'b0}}, col_q};
                if (is_fixed(ekind) || more)
                begin
                    mem_cmd_d = CMD_RD;
                    iss_last_d = is_fixed(ekind) ? (rem_q == LEN_ONE) : (ekind == BST_SINGLE);
                    col_d = col_q + 9'h001;
                    if (ekind != BST_INCR)
                        rem_d = rem_q - LEN_ONE;
                    if ((is_fixed(ekind) && rem_q == LEN_ONE) || col_q == COL_LAST)
                        state_d = S_DRAIN;
                end
                else
                begin
                    // read the next column ahead of the next request
                    mem_cmd_d = CMD_RD;
                    iss_pf_d = 1'b1;
                    pf_valid_d = 1'b0;
                    pf_bank_d = bank_q;
                    pf_row_d = row_q;
                    pf_col_d = col_q;
                    state_d = S_DRAIN;
                end
            end
            S_DRAIN:
                if (pipe_q[0][2] == 1'b0 && pipe_q[1][2] == 1'b0 && pipe_q[2][2] == 1'b0
                    && mem_cmd_q != CMD_RD)
                begin
                    req_ready_d = 1'b1;
                    state_d = S_IDLE;
                end
            default:
                state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            kind_q <= BST_SINGLE;
            bank_q <= '0;
            row_q <= '0;
            col_q <= '0;
            rem_q <= '0;
            first_q <= 1'b0;
            req_ready_q <= 1'b1;
            mem_cmd_q <= CMD_NOP;
            mem_bank_q <= '0;
            mem_addr_q <= '0;
            iss_pf_q <= 1'b0;
            iss_last_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_last_q <= 1'b0;
            rd_data_q <= '0;
            pf_valid_q <= 1'b0;
            pf_data_q <= '0;
            pf_bank_q <= '0;
            pf_row_q <= '0;
            pf_col_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            kind_q <= kind_d;
            bank_q <= bank_d;
            row_q <= row_d;
            col_q <= col_d;
            rem_q <= rem_d;
            first_q <= first_d;
            req_ready_q <= req_ready_d;
            mem_cmd_q <= mem_cmd_d;
            mem_bank_q <= mem_bank_d;
            mem_addr_q <= mem_addr_d;
            iss_pf_q <= iss_pf_d;
            iss_last_q <= iss_last_d;
            rd_valid_q <= rd_valid_d;
            rd_last_q <= rd_last_d;
            rd_data_q <= rd_data_d;
            pf_valid_q <= pf_valid_d;
            pf_data_q <= pf_data_d;
            pf_bank_q <= pf_bank_d;
            pf_row_q <= pf_row_d;
            pf_col_q <= pf_col_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // cycles since the previous command, for spacing checks
    logic [4:0] gap_q;
    sdrs_cmd_e last_cmd_q;
    logic accept;
    assign accept = state_q == S_IDLE && req_valid && req_ready_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_q <= GAP_MAX;
            last_cmd_q <= CMD_NOP;
        end
        else if (mem_cmd_q != CMD_NOP)
        begin
            gap_q <= 5'h01;
            last_cmd_q <= mem_cmd_q;
        end
        else if (gap_q != GAP_MAX)
            gap_q <= gap_q + 5'h01;
    end

    a_single_served: assert property (@(posedge clock) disable iff (!rst_n)
        accept && req_kind == BST_SINGLE |-> ##[1:80] rd_last_q)
        else $error("single read never completed");
    a_open_row_hit: assert property (@(posedge clock) disable iff (!rst_n)
        accept && open_q[req_bank] && orow_q[req_bank] == req_row
        |=> state_q == S_READ ##1 mem_cmd_q == CMD_RD)
        else $error("open row hit did not read directly");
    a_miss_precharge: assert property (@(posedge clock) disable iff (!rst_n)
        accept && open_q[req_bank] && orow_q[req_bank] != req_row
        |=> state_q == S_PRE ##1 mem_cmd_q == CMD_PRE)
        else $error("row miss without precharge");
    a_trp_spacing: assert property (@(posedge clock) disable iff (!rst_n)
        mem_cmd_q == CMD_ACT && last_cmd_q == CMD_PRE |-> gap_q == {1'b0, eff_tim(cfg_trp)})
        else $error("precharge to activate spacing wrong");
    a_trcd_spacing: assert property (@(posedge clock) disable iff (!rst_n)
        mem_cmd_q == CMD_RD && last_cmd_q == CMD_ACT |-> gap_q == {1'b0, rcd})
        else $error("activate to read spacing wrong");
    a_cas_three: assert property (@(posedge clock) disable iff (!rst_n)
        mem_cmd_q == CMD_RD && !iss_pf_q && cfg_cas_lat3 |-> ##4 rd_valid_q)
        else $error("cas 3 data not returned on time");
    a_cas_two: assert property (@(posedge clock) disable iff (!rst_n)
        mem_cmd_q == CMD_RD && !iss_pf_q && !cfg_cas_lat3 |-> ##3 rd_valid_q)
        else $error("cas 2 data not returned on time");
    a_single_prefetch: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == S_READ && kind_q == BST_SINGLE && rem_q == 5'h00
        |=> mem_cmd_q == CMD_RD && iss_pf_q)
        else $error("next column not anticipated");
    a_fixed_no_pf: assert property (@(posedge clock) disable iff (!rst_n)
        mem_cmd_q == CMD_RD && iss_pf_q && !$past(burst_break) |-> !is_fixed($past(kind_q)))
        else $error("fixed burst read beyond its length");
    a_break_incr: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == S_READ && is_fixed(kind_q) && burst_break |=> kind_q == BST_INCR)
        else $error("broken burst not turned incrementing");
    a_closed_act: assert property (@(posedge clock) disable iff (!rst_n)
        accept && !open_q[req_bank] |=> state_q == S_ACT ##1 mem_cmd_q == CMD_ACT)
        else $error("closed bank read without activate");
endmodule : sdrs_read_sched
`default_nettype wire

// ==== core/sdrs_wait_timer.sv ====
/*
 * down counter for command spacing; expired is high when one cycle is left.
 * assumes a synchronous load from the scheduler and its released reset.
 */
`timescale 1ns/1ns
`default_nettype none
module sdrs_wait_timer
    import sdrs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [TIM_W-1:0] load_val,
    output logic expired
);
    logic [TIM_W-1:0] cnt_q;
    logic [TIM_W-1:0] cnt_d;

    // ------------------------------------------------------------
    // count
    // ------------------------------------------------------------
    // load wins, else count down to one and hold
    always_comb
    begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = load_val;
        else if (cnt_q > TIM_MIN)
            cnt_d = cnt_q - TIM_MIN;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= TIM_MIN;
        else
            cnt_q <= cnt_d;
    end

    assign expired = (cnt_q <= TIM_MIN);
endmodule : sdrs_wait_timer
`default_nettype wire

// ==== include/sdrs_pkg.sv ====
/*
 * shared constants, types and helpers of the sdram read path scheduler.
 * assumes a single clock domain; the sdram device runs on the same clock.
 */
package sdrs_pkg;

    // ------------------------------------------------------------
    // geometry and timing fields
    // ------------------------------------------------------------
    localparam int BANK_W = 2;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int DATA_W = 16;
    localparam int TIM_W = 4;
    localparam int NBANK = 4;
    localparam int PIPE_N = 3;
    localparam logic [COL_W-1:0] COL_LAST = 9'h1ff;
    localparam logic [TIM_W-1:0] TIM_MIN = 4'h1;
    localparam logic [4:0] LEN_ONE = 5'h01;
    localparam logic [4:0] LEN_FIX4 = 5'h04;
    localparam logic [4:0] LEN_FIX8 = 5'h08;
    localparam logic [4:0] LEN_FIX16 = 5'h10;
    localparam logic [4:0] GAP_MAX = 5'h1f;

    // ------------------------------------------------------------
    // commands, burst kinds, scheduler states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_NOP = 2'h0,
        CMD_PRE = 2'h1,
        CMD_ACT = 2'h2,
        CMD_RD = 2'h3
    } sdrs_cmd_e;

    typedef enum logic [2:0] {
        BST_SINGLE = 3'h0,
        BST_INCR = 3'h1,
        BST_FIX4 = 3'h2,
        BST_FIX8 = 3'h3,
        BST_FIX16 = 3'h4
    } sdrs_burst_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_PRE = 3'h1,
        S_WRP = 3'h3,
        S_ACT = 3'h2,
        S_WRCD = 3'h6,
        S_READ = 3'h7,
        S_DRAIN = 3'h5
    } sdrs_state_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a zero delay field is taken as one cycle
    function automatic logic [TIM_W-1:0] eff_tim(input logic [TIM_W-1:0] v);
        eff_tim = (v == '0) ? TIM_MIN : v;
    endfunction : eff_tim

    function automatic logic is_fixed(input sdrs_burst_e k);
        is_fixed = (k == BST_FIX4) || (k == BST_FIX8) || (k == BST_FIX16);
    endfunction : is_fixed

    function automatic logic [4:0] burst_words(input sdrs_burst_e k);
        unique case (k)
            BST_FIX4: burst_words = LEN_FIX4;
            BST_FIX8: burst_words = LEN_FIX8;
            BST_FIX16: burst_words = LEN_FIX16;
            default: burst_words = LEN_ONE;
        endcase
    endfunction : burst_words

endpackage : sdrs_pkg
